// [hw/htt_pkg.sv]
package htt_pkg;

  // Register byte offsets on the control bus.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIV_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] CNT_OFS = 8'h0C;

  // Control register field positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_REF_GATE = 2;
  localparam int CTRL_RANGE_LO = 4;

  // Table entry field positions.
  localparam int B_SYNC = 15;
  localparam int B_SHIFT = 14;
  localparam int B_SEL_HI = 13;
  localparam int B_SEL_LO = 12;
  localparam int B_LAST = 10;
  localparam int B_CH1 = 9;
  localparam int COUNT_W = 9;
  localparam int CTRL_W = 7;

  // Table placement in processor memory.
  localparam logic [15:0] TABLE_BASE = 16'h03E0;
  localparam int TABLE_WORDS = 16;

  // Feedback divisor limits and value after reset.
  localparam logic [12:0] DIV_MIN = 13'h0100;
  localparam logic [12:0] DIV_MAX = 13'h1000;
  localparam logic [12:0] DIV_RESET = 13'h0400;

  // Range divider masks for divide by 2, 4 and 8.
  localparam logic [2:0] MASK_DIV2 = 3'h1;
  localparam logic [2:0] MASK_DIV4 = 3'h3;
  localparam logic [2:0] MASK_DIV8 = 3'h7;

  // Cycles each fetch phase lasts, minus one.
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {F_IDLE, F_WAIT_ACK, F_PHASES, F_RELEASE} fetch_e;

endpackage : htt_pkg

// [hw/line_sync_divider.sv]
`timescale 1ns/10ps
`default_nettype none

module line_sync_divider #(
  parameter int W = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic [W-1:0] divisor,
  output logic line_sync
);

  logic [W-1:0] count;

  // Divide-by-N: one line sync pulse every divisor ticks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      line_sync <= 1'b0;
    end else begin
      line_sync <= 1'b0;
      if (tick) begin
        if (count >= divisor - W'(1)) begin
          count <= '0;
          line_sync <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule : line_sync_divider
`default_nettype wire

// [hw/horizontal_timing_table_sequencer.sv]
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module horizontal_timing_table_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic synth_base_clock,
  input wire logic bus_hold_ack,
  input wire logic [15:0] table_data,
  input wire logic cpu_timer_out,
  output logic hold_request,
  output logic fetch_phase0_n,
  output logic fetch_phase1_n,
  output logic fetch_phase2_n,
  output logic dram_read_req,
  output logic ram_addr_drive,
  output logic [3:0] latched_addr_offset,
  output logic [15:0] table_fetch_addr,
  output logic terminal_count_n,
  output logic down_counter_clock,
  output logic down_counter_load,
  output logic line_sync,
  output logic video_data_enable,
  output logic shift_clock_gate,
  output logic vmem_cycle_sel_hi,
  output logic vmem_cycle_sel_lo,
  output logic last_entry_flag,
  output logic channel1_request,
  output logic gated_line_ref,
  output logic synth_line_sync
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and base clock edges.

  logic [18:0] pin_meta;
  logic [18:0] pin_sync;
  logic base_s;
  logic ack_s;
  logic [15:0] data_s;
  logic timer_s;
  logic base_prev;
  logic base_rise;
  logic half_rate_clock;
  logic half_tick;

  // Two flops on every pin from the processor or the synthesizer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {synth_base_clock, bus_hold_ack, table_data, cpu_timer_out};
      pin_sync <= pin_meta;
    end
  end

  assign {base_s, ack_s, data_s, timer_s} = pin_sync;
  assign base_rise = base_s & ~base_prev;
  assign half_tick = base_rise & half_rate_clock;

  // Halves the synthesizer base clock for the down counter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_prev <= 1'b0;
      half_rate_clock <= 1'b0;
    end else begin
      base_prev <= base_s;
      if (base_rise) begin
        half_rate_clock <= ~half_rate_clock;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file state.

  logic run_en;
  logic ref_gate;
  logic [1:0] range_sel;
  logic [12:0] divisor;
  logic start_req;
  logic aw_free;
  logic w_free;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [12:0] div_in;

  ////////////////////////////////////////////////////////////////////////////
  // Down counter with the lsb done by pulse skipping.

  logic [7:0] cnt_hi;
  logic skip_lsb;
  logic [15:0] buf_word;
  logic buf_valid;
  logic tc;
  htt_pkg::fetch_e state;

  // Expiry only when a fetched entry is waiting and the fetch logic is idle
  // again, so a slow fetch stretches the state instead of losing a fetch.
  assign tc = half_tick & run_en & buf_valid & ~skip_lsb & (cnt_hi == 8'h00) &
              (state == htt_pkg::F_IDLE);

  // Upper eight bits count down; a set lsb swallows one clock pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_hi <= 8'h00;
      skip_lsb <= 1'b0;
    end else if (half_tick && run_en) begin
      if (skip_lsb) begin
        skip_lsb <= 1'b0;
      end else if (tc) begin
        cnt_hi <= buf_word[htt_pkg::COUNT_W-1:1];
        skip_lsb <= buf_word[0];
      end else if (cnt_hi != 8'h00) begin
        cnt_hi <= cnt_hi - 1'b1;
      end
    end
  end

  // Counter clock, load strobe and terminal count, all from the half clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      down_counter_clock <= 1'b0;
      down_counter_load <= 1'b0;
      terminal_count_n <= 1'b1;
    end else begin
      down_counter_clock <= half_tick & run_en & ~skip_lsb;
      down_counter_load <= tc;
      terminal_count_n <= ~tc;
    end
  end

  // Buffered control bits become the active time state on expiry.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_sync <= 1'b0;
      video_data_enable <= 1'b0;
      shift_clock_gate <= 1'b0;
      vmem_cycle_sel_hi <= 1'b0;
      vmem_cycle_sel_lo <= 1'b0;
      last_entry_flag <= 1'b0;
      channel1_request <= 1'b0;
    end else if (tc) begin
      line_sync <= buf_word[htt_pkg::B_SYNC];
      video_data_enable <= buf_word[htt_pkg::B_SYNC] & buf_word[htt_pkg::B_SEL_HI];
      shift_clock_gate <= ~buf_word[htt_pkg::B_SYNC] & buf_word[htt_pkg::B_SHIFT];
      vmem_cycle_sel_hi <= ~buf_word[htt_pkg::B_SYNC] & buf_word[htt_pkg::B_SEL_HI];
      vmem_cycle_sel_lo <= ~buf_word[htt_pkg::B_SYNC] & buf_word[htt_pkg::B_SEL_LO];
      last_entry_flag <= buf_word[htt_pkg::B_LAST];
      channel1_request <= buf_word[htt_pkg::B_CH1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table fetch under bus hold.

  logic [2:0] phase_n;
  logic [1:0] pcnt;
  logic [3:0] offset;
  logic phase2_end;

  assign fetch_phase0_n = phase_n[0];
  assign fetch_phase1_n = phase_n[1];
  assign fetch_phase2_n = phase_n[2];
  assign phase2_end = ~phase_n[2] & (pcnt == htt_pkg::PHASE_LAST);

  // One fetch per time state refills the input registers; the hold
  // request outranks the processor's own DMA channels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= htt_pkg::F_IDLE;
      hold_request <= 1'b0;
      phase_n <= 3'h7;
      pcnt <= 2'h0;
      dram_read_req <= 1'b0;
      ram_addr_drive <= 1'b0;
    end else begin
      case (state)
        htt_pkg::F_IDLE: begin
          if (tc || (start_req && !buf_valid)) begin
            hold_request <= 1'b1;
            state <= htt_pkg::F_WAIT_ACK;
          end
        end
        htt_pkg::F_WAIT_ACK: begin
          if (ack_s) begin
            phase_n <= 3'h6;
            pcnt <= 2'h0;
            dram_read_req <= 1'b1;
            ram_addr_drive <= 1'b1;
            state <= htt_pkg::F_PHASES;
          end
        end
        htt_pkg::F_PHASES: begin
          pcnt <= pcnt + 1'b1;
          if (pcnt == htt_pkg::PHASE_LAST) begin
            dram_read_req <= 1'b0;
            if (!phase_n[2]) begin
              phase_n <= 3'h7;
              ram_addr_drive <= 1'b0;
              hold_request <= 1'b0;
              state <= htt_pkg::F_RELEASE;
            end else begin
              phase_n <= {phase_n[1:0], 1'b1};
            end
          end
        end
        default: begin
          if (!ack_s) begin
            state <= htt_pkg::F_IDLE;
          end
        end
      endcase
    end
  end

  // Input registers take the word at the end of the third phase and hand
  // it over on expiry.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_word <= 16'h0000;
      buf_valid <= 1'b0;
    end else if (phase2_end) begin
      buf_word <= data_s;
      buf_valid <= 1'b1;
    end else if (tc) begin
      buf_valid <= 1'b0;
    end
  end

  // Table offset and the address it forms.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offset <= 4'h0;
      latched_addr_offset <= 4'h0;
      table_fetch_addr <= htt_pkg::TABLE_BASE;
    end else begin
      if (phase2_end) begin
        if (data_s[htt_pkg::B_LAST]) begin
          offset <= 4'h0;
        end else begin
          offset <= offset + 1'b1;
        end
      end
      latched_addr_offset <= offset;
      table_fetch_addr <= htt_pkg::TABLE_BASE + {11'h000, offset, 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synthesizer range divider, feedback divider and reference gate.

  logic [2:0] range_cnt;
  logic [2:0] range_mask;
  logic range_tick;

  assign range_mask = (range_sel == 2'h0) ? htt_pkg::MASK_DIV2 :
                      (range_sel == 2'h1) ? htt_pkg::MASK_DIV4 : htt_pkg::MASK_DIV8;
  assign range_tick = base_rise & ((range_cnt & range_mask) == range_mask);

  // Free-running prescaler on base clock edges.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      range_cnt <= 3'h0;
      gated_line_ref <= 1'b0;
    end else begin
      if (base_rise) begin
        range_cnt <= range_cnt + 1'b1;
      end
      gated_line_ref <= ref_gate & timer_s;
    end
  end

  // Feedback divisor: one step moves the output by one reference frequency.
  line_sync_divider #(.W(13)) feedback_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(range_tick),
    .divisor(divisor),
    .line_sync(synth_line_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  assign s_axi_awready = aw_free;
  assign s_axi_wready = w_free;
  assign do_write = ~aw_free & ~w_free & ~s_axi_bvalid;
  assign div_in = w_data[12:0];

  // Address and data are taken in either order; response after both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_free <= 1'b1;
      w_free <= 1'b1;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= htt_pkg::RESP_OKAY;
    end else begin
      if (aw_free && s_axi_awvalid) begin
        aw_free <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (w_free && s_axi_wvalid) begin
        w_free <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == htt_pkg::CTRL_OFS || aw_addr == htt_pkg::DIV_OFS) begin
          s_axi_bresp <= htt_pkg::RESP_OKAY;
        end else if (aw_addr == htt_pkg::STAT_OFS || aw_addr == htt_pkg::CNT_OFS) begin
          s_axi_bresp <= htt_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= htt_pkg::RESP_DECERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_free <= 1'b1;
        w_free <= 1'b1;
      end
    end
  end

  // Writable fields; divisor writes are clamped to the legal range.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_en <= 1'b0;
      ref_gate <= 1'b0;
      range_sel <= 2'h0;
      divisor <= htt_pkg::DIV_RESET;
      start_req <= 1'b0;
    end else begin
      start_req <= 1'b0;
      if (do_write && aw_addr == htt_pkg::CTRL_OFS && w_strb[0]) begin
        run_en <= w_data[htt_pkg::CTRL_RUN];
        ref_gate <= w_data[htt_pkg::CTRL_REF_GATE];
        range_sel <= w_data[htt_pkg::CTRL_RANGE_LO +: 2];
        start_req <= w_data[htt_pkg::CTRL_START];
      end else if (do_write && aw_addr == htt_pkg::DIV_OFS && (&w_strb[1:0])) begin
        if ({w_data[31:13] != 19'h0_0000} || div_in > htt_pkg::DIV_MAX) begin
          divisor <= htt_pkg::DIV_MAX;
        end else if (div_in < htt_pkg::DIV_MIN) begin
          divisor <= htt_pkg::DIV_MIN;
        end else begin
          divisor <= div_in;
        end
      end
    end
  end

  // Read channel: one read at a time, data held until taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= htt_pkg::RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= htt_pkg::RESP_OKAY;
      if (s_axi_araddr == htt_pkg::CTRL_OFS) begin
        s_axi_rdata <= 32'({range_sel, 1'b0, ref_gate, 1'b0, run_en});
      end else if (s_axi_araddr == htt_pkg::DIV_OFS) begin
        s_axi_rdata <= 32'(divisor);
      end else if (s_axi_araddr == htt_pkg::STAT_OFS) begin
        s_axi_rdata <= 32'({hold_request, buf_valid, buf_word[15:9], offset});
      end else if (s_axi_araddr == htt_pkg::CNT_OFS) begin
        s_axi_rdata <= 32'({cnt_hi, skip_lsb});
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= htt_pkg::RESP_DECERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_SYNC_FROM_ENTRY: assert property (tc |=> line_sync == $past(buf_word[15]))
    else $error("line sync does not follow the loaded entry");
  AST_VIDEO_DATA_ENABLE_ONLY_SYNC: assert property (video_data_enable |-> line_sync)
    else $error("data enable outside a sync state");
  AST_SHIFT_NOT_SYNC: assert property (shift_clock_gate |-> !line_sync)
    else $error("shift clock gated on during sync");
  AST_SEL_NOT_SYNC: assert property ((vmem_cycle_sel_hi || vmem_cycle_sel_lo) |-> !line_sync)
    else $error("cycle select during sync");
  AST_LAST_RESETS: assert property (phase2_end && data_s[10] |=> offset == 4'h0)
    else $error("offset not cleared after last entry");
  AST_OFFSET_STEP: assert property (phase2_end && !data_s[10] |=> offset == $past(offset) + 4'h1)
    else $error("offset did not step by one");
  AST_CH1_FROM_ENTRY: assert property (tc |=> channel1_request == $past(buf_word[9]))
    else $error("channel 1 request does not follow entry");
  AST_LSB_SKIP: assert property (half_tick && run_en && skip_lsb |=> !down_counter_clock && !skip_lsb)
    else $error("lsb pulse not swallowed");
  AST_LOAD_ON_TC: assert property (tc |=> down_counter_load && !terminal_count_n && cnt_hi == $past(buf_word[8:1]))
    else $error("count not loaded on expiry");
  AST_HOLD_ON_TC: assert property (tc |=> hold_request)
    else $error("no hold request after expiry");
  AST_PHASE_SEQ: assert property ($fell(phase_n[0]) |-> !phase_n[0] [*4] ##1 !phase_n[1] [*4] ##1 !phase_n[2])
    else $error("fetch phases out of order");
  AST_HOLD_CAUSE: assert property ($rose(hold_request) |-> $past(tc || start_req))
    else $error("hold request without cause");

  COV_SYNC_STATE: cover property (tc && buf_word[15]);
  COV_LAST_ENTRY: cover property (phase2_end && data_s[10]);
  COV_SKIP: cover property (half_tick && run_en && skip_lsb);
  COV_FETCH_DONE: cover property ($fell(hold_request));

endmodule : horizontal_timing_table_sequencer
`default_nettype wire

// [testbench/host_cpu_model.sv]
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
// Processor side of the table fetch: grants bus hold and serves table words.
module host_cpu_model #(
  parameter int ACK_MAX = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hold_request,
  input wire logic [15:0] table_fetch_addr,
  input wire logic channel1_request,
  output logic bus_hold_ack,
  output logic [15:0] table_data,
  output logic [7:0] ch1_cycles
);
  logic [15:0] mem [16]; // Timing table in low memory.
  logic [15:0] idx;
  logic [3:0] delay;
  logic ch1_prev;

  // Word index inside the table window.
  assign idx = (table_fetch_addr - 16'h03E0) >> 1;

  ////////////////////////////////////////
  // Acknowledge hold after a random wait; drop the ack and invert the data after release.
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_hold_ack <= 1'h0;
      table_data <= 16'h0000;
      delay <= 4'h0;
    end else if (hold_request && !bus_hold_ack) begin
      if (delay == 4'h0) begin
        bus_hold_ack <= 1'h1;
        table_data <= mem[idx[3:0]];
        delay <= 4'($urandom_range(ACK_MAX));
      end else begin
        delay <= delay - 4'h1;
      end
    end else if (!hold_request && bus_hold_ack) begin
      bus_hold_ack <= 1'h0;
      table_data <= ~table_data; // Released bus no longer shows the word.
    end
  end

  ////////////////////////////////////////
  // One channel 1 cycle is run for each new request.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ch1_cycles <= 8'h00;
      ch1_prev <= 1'h0;
    end else begin
      ch1_prev <= channel1_request;
      if (channel1_request && !ch1_prev) begin
        ch1_cycles <= ch1_cycles + 8'h01;
      end
    end
  end
endmodule : host_cpu_model
`default_nettype wire

// [testbench/horizontal_timing_table_sequencer_bench.sv]
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
// Self-checking bench for the line timing sequencer.
module horizontal_timing_table_sequencer_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ch1_cycles;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, latched_addr_offset;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic synth_base_clock, bus_hold_ack, cpu_timer_out, hold_request, ph0_prev;
  logic fetch_phase0_n, fetch_phase1_n, fetch_phase2_n, dram_read_req, ram_addr_drive;
  logic [15:0] table_data, table_fetch_addr, w, lw, tbl [5];
  logic terminal_count_n, down_counter_clock, down_counter_load, line_sync, video_data_enable;
  logic shift_clock_gate, vmem_cycle_sel_hi, vmem_cycle_sel_lo, last_entry_flag;
  logic channel1_request, gated_line_ref, synth_line_sync;
  int n_mismatch = 0, tests_run = 0, cyc = 0, pend = 0, ld_idx = 0, f_idx = 0, loads = 0;
  int nsync = 0, last_sync = 0, per = 0, bdiv = 0, p1, p2, last_tc = 0, nclk = 0;

  horizontal_timing_table_sequencer dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .synth_base_clock(synth_base_clock), .bus_hold_ack(bus_hold_ack), .table_data(table_data),
    .cpu_timer_out(cpu_timer_out), .hold_request(hold_request),
    .fetch_phase0_n(fetch_phase0_n), .fetch_phase1_n(fetch_phase1_n),
    .fetch_phase2_n(fetch_phase2_n), .dram_read_req(dram_read_req),
    .ram_addr_drive(ram_addr_drive), .latched_addr_offset(latched_addr_offset),
    .table_fetch_addr(table_fetch_addr), .terminal_count_n(terminal_count_n),
    .down_counter_clock(down_counter_clock), .down_counter_load(down_counter_load),
    .line_sync(line_sync), .video_data_enable(video_data_enable),
    .shift_clock_gate(shift_clock_gate), .vmem_cycle_sel_hi(vmem_cycle_sel_hi),
    .vmem_cycle_sel_lo(vmem_cycle_sel_lo), .last_entry_flag(last_entry_flag),
    .channel1_request(channel1_request), .gated_line_ref(gated_line_ref),
    .synth_line_sync(synth_line_sync));

  host_cpu_model host_u (.aclk(aclk), .aresetn(aresetn), .hold_request(hold_request),
    .table_fetch_addr(table_fetch_addr), .channel1_request(channel1_request),
    .bus_hold_ack(bus_hold_ack), .table_data(table_data), .ch1_cycles(ch1_cycles));

  ////////////////////////////////////////
  // Compare and count; report a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Print the verdict and stop.
  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // One register write; both channels offered together, each released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    resp = s_axi_bresp;
  endtask : axi_wr

  // One register read.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    v = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : axi_rd

  // Period of the feedback sync, taken after it has settled.
  task automatic period(output int p);
    int n0;
    n0 = nsync;
    wait (nsync >= n0 + 3);
    p = per;
  endtask : period

  // Divisor write is held inside 256..4096.
  function automatic logic [31:0] clamp_div(input logic [31:0] v);
    if (v[12:0] < 13'h0100) return 32'h0000_0100;
    if (v[12:0] > 13'h1000) return 32'h0000_1000;
    return {19'h0, v[12:0]};
  endfunction : clamp_div

  // Line outputs expected from an entry; data enable only counts in a sync state.
  function automatic logic [31:0] exp_state(input logic [15:0] e);
    if (e[15]) return {25'h0, 1'h1, e[13], 3'h0, e[10], e[9]};
    return {25'h0, 2'h0, e[14], e[13], e[12], e[10], e[9]};
  endfunction : exp_state

  ////////////////////////////////////////
  // Clock, base clock of period eight cycles, and hang limit.
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (bdiv == 3) begin
      bdiv = 0;
      synth_base_clock <= ~synth_base_clock;
    end else begin
      bdiv++;
    end
    if (cyc == 95000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // Watches loads, fetches and the feedback sync.
  always @(posedge aclk) begin
    if (aresetn === 1'h1) begin
      if (pend == 1) begin
        w = tbl[ld_idx];
        check({25'h0, line_sync, video_data_enable, shift_clock_gate,
          vmem_cycle_sel_hi, vmem_cycle_sel_lo, last_entry_flag, channel1_request},
          exp_state(w));
        check(hold_request, 1'h1);
        ld_idx = w[10] ? 0 : ld_idx + 1;
        lw = w;
        loads++;
      end
      if (pend != 0) pend--;
      if (terminal_count_n === 1'h0) begin
        pend = 2;
        check(down_counter_load, 1'h1);
        if (loads > 0) begin
          check(cyc - last_tc, 16 * (1 + lw[0] + lw[8:1]));
          check(nclk, 1 + lw[8:1]);
        end
        last_tc = cyc;
        nclk = 0;
      end
      if (down_counter_clock === 1'h1) nclk++;
      if (ph0_prev === 1'h1 && fetch_phase0_n === 1'h0) begin
        check(latched_addr_offset, f_idx);
        check(table_fetch_addr, htt_pkg::TABLE_BASE + 16'(2 * f_idx));
        check({dram_read_req, ram_addr_drive}, 2'h3);
        f_idx = tbl[f_idx][10] ? 0 : f_idx + 1;
      end
      ph0_prev = fetch_phase0_n;
      if (synth_line_sync === 1'h1) begin
        per = cyc - last_sync;
        last_sync = cyc;
        nsync++;
      end
    end
  end

  ////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(7168));
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cpu_timer_out, synth_base_clock} = '0;
    s_axi_wstrb = 4'hF;
    tbl = '{16'hF800, 16'h2200, 16'h5000, 16'h3000, 16'h0600};
    for (int i = 0; i < 5; i++) begin
      tbl[i][8:0] = 9'($urandom_range(2, 40));
      host_u.mem[i] = tbl[i];
    end
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check({hold_request, terminal_count_n, fetch_phase0_n, fetch_phase1_n, fetch_phase2_n},
      5'h0F);
    axi_rd(htt_pkg::STAT_OFS, d, r);
    check(d, 32'h0000_0000);
    axi_rd(htt_pkg::DIV_OFS, d, r);
    check(d, {19'h0, htt_pkg::DIV_RESET});
    axi_rd(8'h10, d, r);
    check({r, d}, {htt_pkg::RESP_DECERR, 32'h0000_0000});
    axi_wr(8'h14, 32'h0000_FFFF, r);
    check(r, htt_pkg::RESP_DECERR);
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'h0000 : (i == 1) ? 16'h1FFF : 16'($urandom_range(0, 8191));
      axi_wr(htt_pkg::DIV_OFS, {16'h0, w}, r);
      axi_rd(htt_pkg::DIV_OFS, d, r);
      check(d, clamp_div({16'h0, w}));
    end
    for (int g = 0; g < 2; g++) begin
      axi_wr(htt_pkg::CTRL_OFS, 32'(g) << htt_pkg::CTRL_REF_GATE, r);
      for (int t = 0; t < 2; t++) begin
        cpu_timer_out <= t[0];
        repeat (6) @(posedge aclk);
        check(gated_line_ref, t[0] & g[0]);
      end
    end
    check(hold_request, 1'h0);
    axi_wr(htt_pkg::DIV_OFS, 32'h0000_0100, r);
    axi_wr(htt_pkg::CTRL_OFS, (1 << htt_pkg::CTRL_RUN) | (1 << htt_pkg::CTRL_START), r);
    wait (loads >= 10);
    repeat (8) @(posedge aclk);
    check(ch1_cycles, 8'h04);
    period(p1);
    axi_wr(htt_pkg::DIV_OFS, 32'h0000_0200, r);
    period(p2);
    check(p2, 2 * p1);
    axi_wr(htt_pkg::DIV_OFS, 32'h0000_0100, r);
    axi_wr(htt_pkg::CTRL_OFS, (1 << htt_pkg::CTRL_RUN) | (1 << htt_pkg::CTRL_RANGE_LO), r);
    period(p2);
    check(p2, 2 * p1);
    end_of_test();
  end
endmodule : horizontal_timing_table_sequencer_bench
`default_nettype wire
